// file: core/psg_pkg.sv
package psg_pkg;
   localparam int CLK_PERIOD_PS = 5000;
   localparam int NS_PER_US = 1000;
   // Address layout: [15] instance level, [14:12] member of parameter set, [11:0] attribute
   localparam int ADDR_W = 16;
   localparam int DATA_W = 64;
   localparam int INST_BIT = 15;
   localparam int MEMB_LSB = 12;
   localparam int ATTR_W = 12;
   // Service codes
   localparam logic [7:0] SVC_GET_LIST = 8'h03;
   localparam logic [7:0] SVC_SET_LIST = 8'h04;
   localparam logic [7:0] SVC_GET_SINGLE = 8'h0e;
   localparam logic [7:0] SVC_SET_SINGLE = 8'h10;
   // Class attributes
   localparam logic [11:0] CA_REVISION = 12'h001;
   localparam logic [11:0] CA_MAX_INST = 12'h002;
   localparam logic [11:0] CA_NUM_INST = 12'h003;
   localparam logic [11:0] CA_MAX_CLASS_ID = 12'h006;
   localparam logic [11:0] CA_MAX_INST_ID = 12'h007;
   localparam logic [15:0] CLASS_REVISION = 16'h0001; // Arbitrary value
   localparam logic [15:0] INST_COUNT = 16'h0001;
   // Instance attributes
   localparam logic [11:0] IA_TIME_SYNC_ENABLE = 12'h001;
   localparam logic [11:0] IA_LOCKED = 12'h002;
   localparam logic [11:0] IA_TIME_US = 12'h003;
   localparam logic [11:0] IA_TIME_NS = 12'h004;
   localparam logic [11:0] IA_MASTER_OFFSET = 12'h005;
   localparam logic [11:0] IA_PEAK_OFFSET = 12'h006;
   localparam logic [11:0] IA_LINK_DELAY = 12'h007;
   localparam logic [11:0] IA_PULSE_PARAMS = 12'h300;
   localparam logic [11:0] IA_IRQ_STATUS = 12'h3f0;
   localparam logic [11:0] IA_IRQ_MASK = 12'h3f1;
   // Members of the pulse parameter set
   localparam logic [2:0] M_PRI_PERIOD = 3'h0;
   localparam logic [2:0] M_PRI_PHASE = 3'h1;
   localparam logic [2:0] M_SEC_PERIOD = 3'h2;
   localparam logic [2:0] M_SEC_PHASE = 3'h3;
   localparam logic [2:0] M_WIDTH_US = 3'h4;
   // Ranges and defaults
   localparam logic [31:0] PRI_PERIOD_MIN = 32'h000186a0;
   localparam logic [31:0] PRI_PERIOD_MAX = 32'h003d0900;
   localparam logic [31:0] SEC_PERIOD_MIN = 32'h00002710;
   localparam logic [31:0] SEC_PERIOD_MAX = 32'h3b9ac9ff;
   localparam logic [31:0] WIDTH_MIN = 32'h00000001;
   localparam logic [31:0] WIDTH_MAX = 32'h000001f4;
   localparam logic [31:0] PRI_PERIOD_RST = 32'h00000000;
   localparam logic [31:0] PHASE_RST = 32'h00000000;
   localparam logic [31:0] SEC_PERIOD_RST = 32'h00000000;
   localparam logic [31:0] WIDTH_RST = 32'h00000004;
   // Interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_PULSE = 0;
   localparam int IRQ_LOCK_CHG = 1;
   localparam int IRQ_REJECT = 2;
endpackage : psg_pkg

// file: core/psg_pulse_gen.sv
`timescale 1ns/1ps
module psg_pulse_gen (
   input wire logic clk_sys,
   input wire logic rst,
   psg_pulse_if.gen pif
);
   typedef enum logic [1:0] {PG_OFF, PG_SEED, PG_RUN} psg_pg_state_t;
   typedef struct packed {
      psg_pg_state_t st;
      logic [31:0] rem;
      logic [63:0] prevT;
      logic [31:0] widthLeft;
      logic pulse;
      logic fire;
   } psg_pg_t;
   psg_pg_t s_r, s_nxt;
   logic [63:0] delta;
   logic [63:0] rel;
   logic [32:0] sum;

   assign pif.pulse = s_r.pulse;
   assign pif.fire = s_r.fire;

   always_comb begin
      s_nxt = s_r;
      s_nxt.fire = 1'b0;
      s_nxt.prevT = pif.timeNs;
      delta = pif.timeNs - s_r.prevT;
      rel = pif.timeNs - {32'h0, pif.phase};
      sum = {1'b0, s_r.rem} + {1'b0, delta[31:0]};
      // Width runs down on elapsed time, so a stalled time base stretches the pulse
      if (s_r.pulse) begin
         if ({32'h0, s_r.widthLeft} <= delta) begin
            s_nxt.pulse = 1'b0;
         end else begin
            s_nxt.widthLeft = s_r.widthLeft - delta[31:0];
         end
      end
      unique case (s_r.st)
         PG_OFF: begin
            s_nxt.pulse = 1'b0;
            if (pif.period != 32'h0) begin
               s_nxt.st = PG_SEED;
            end
         end
         PG_SEED: begin
            // Full modulo only on a reseed; steady state is one add per cycle
            if (pif.period == 32'h0) begin
               // A period cleared during the reseed must not reach the divider
               s_nxt.st = PG_OFF;
               s_nxt.pulse = 1'b0;
            end else begin
               s_nxt.rem = 32'((rel % {32'h0, pif.period}));
               s_nxt.st = PG_RUN;
            end
         end
         PG_RUN: begin
            if (pif.period == 32'h0) begin
               s_nxt.st = PG_OFF;
               s_nxt.pulse = 1'b0;
            end else if (pif.reload || delta >= {32'h0, pif.period}) begin
               s_nxt.st = PG_SEED;
            end else if (sum >= {1'b0, pif.period}) begin
               s_nxt.rem = 32'(sum - {1'b0, pif.period});
               s_nxt.pulse = 1'b1;
               s_nxt.fire = 1'b1;
               s_nxt.widthLeft = pif.widthNs;
            end else begin
               s_nxt.rem = sum[31:0];
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_r <= '{st: PG_OFF, rem: 32'h0, prevT: 64'h0, widthLeft: 32'h0, pulse: 1'b0,
                  fire: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   a_off_quiet: assert property (@(posedge clk_sys) disable iff (rst)
      (pif.period == 32'h0) [*2] |-> !s_r.pulse)
      else $error("Pulse active while period is zero");
   a_fire_starts: assert property (@(posedge clk_sys) disable iff (rst)
      s_r.fire |-> s_r.pulse && !$past(s_r.pulse))
      else $error("Fire without a fresh pulse");
   c_pulse_seen: cover property (@(posedge clk_sys) disable iff (rst) $rose(s_r.pulse));
   c_pulse_end: cover property (@(posedge clk_sys) disable iff (rst) $fell(s_r.pulse));
endmodule : psg_pulse_gen

// file: core/psg_pulse_if.sv
`timescale 1ns/1ps
interface psg_pulse_if;
   logic [63:0] timeNs;
   logic [31:0] period;
   logic [31:0] phase;
   logic [31:0] widthNs;
   logic reload;
   logic pulse;
   logic fire;
   modport ctrl (output timeNs, period, phase, widthNs, reload, input pulse, fire);
   modport gen (input timeNs, period, phase, widthNs, reload, output pulse, fire);
endinterface : psg_pulse_if

// file: core/psg_time_sync.sv
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module psg_time_sync (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] svcCode,
   input wire logic [63:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [63:0] rdata,
   output logic svcError,
   input wire logic [63:0] sysTimeNs,
   input wire logic lockedIn,
   input wire logic [63:0] masterOffsetIn,
   input wire logic [63:0] linkDelayIn,
   output logic timeSyncEnable,
   output logic primaryPulse,
   output logic irq
);
   typedef struct packed {
      logic enable;
      logic [31:0] priPeriod;
      logic [31:0] priPhase;
      logic [31:0] secPeriod;
      logic [31:0] secPhase;
      logic [31:0] widthUs;
      logic [63:0] timeNs;
      logic locked;
      logic [63:0] offset;
      logic [63:0] peak;
      logic [63:0] delay;
      logic [63:0] rdata;
      logic err;
      logic reload;
      logic [psg_pkg::IRQ_W-1:0] stat;
      logic [psg_pkg::IRQ_W-1:0] mask;
      logic irq;
      logic primed;
   } psg_ts_t;
   psg_ts_t s_r, s_nxt;
   psg_pulse_if pif ();

   function automatic logic [31:0] us_to_ns(input logic [31:0] us);
      return 32'(us * psg_pkg::NS_PER_US);
   endfunction : us_to_ns

   function automatic logic [63:0] mag(input logic [63:0] v);
      return v[63] ? 64'(-v) : v;
   endfunction : mag

   // Width must stay under every enabled period; a zero period is disabled
   function automatic logic width_fits(input logic [31:0] w, input logic [31:0] p0,
                                       input logic [31:0] p1);
      logic ok;
      ok = (w >= psg_pkg::WIDTH_MIN) && (w <= psg_pkg::WIDTH_MAX);
      if (p0 != 32'h0 && us_to_ns(w) >= p0) ok = 1'b0;
      if (p1 != 32'h0 && us_to_ns(w) >= p1) ok = 1'b0;
      return ok;
   endfunction : width_fits

   logic inst;
   logic [11:0] attr;
   logic [2:0] memb;
   logic [31:0] w32;
   logic getOk;
   logic setOk;
   logic valOk;
   logic [63:0] q;

   assign pif.timeNs = s_r.timeNs;
   assign pif.period = s_r.priPeriod;
   assign pif.phase = s_r.priPhase;
   assign pif.widthNs = us_to_ns(s_r.widthUs);
   assign pif.reload = s_r.reload;

   psg_pulse_gen u_gen (
      .clk_sys(clk_sys),
      .rst(rst),
      .pif(pif)
   );

   assign rdata = s_r.rdata;
   assign svcError = s_r.err;
   assign timeSyncEnable = s_r.enable;
   assign primaryPulse = pif.pulse;
   assign irq = s_r.irq;

   always_comb begin
      s_nxt = s_r;
      inst = addr[psg_pkg::INST_BIT];
      attr = addr[psg_pkg::ATTR_W-1:0];
      memb = addr[psg_pkg::MEMB_LSB +: 3];
      w32 = wdata[31:0];
      q = 64'h0;
      valOk = 1'b0;
      s_nxt.err = 1'b0;
      s_nxt.reload = 1'b0;
      s_nxt.rdata = 64'h0;
      s_nxt.timeNs = sysTimeNs;
      s_nxt.locked = lockedIn;
      s_nxt.offset = masterOffsetIn;
      s_nxt.delay = linkDelayIn;
      if (mag(masterOffsetIn) > s_r.peak) begin
         s_nxt.peak = mag(masterOffsetIn);
      end
      getOk = rd && (svcCode == psg_pkg::SVC_GET_SINGLE ||
                     (inst && svcCode == psg_pkg::SVC_GET_LIST));
      setOk = wr && inst && (svcCode == psg_pkg::SVC_SET_SINGLE ||
                             svcCode == psg_pkg::SVC_SET_LIST);
      if (rd) begin
         if (!inst) begin
            unique case (attr)
               psg_pkg::CA_REVISION: q = {48'h0, psg_pkg::CLASS_REVISION};
               psg_pkg::CA_MAX_INST, psg_pkg::CA_NUM_INST: q = {48'h0, psg_pkg::INST_COUNT};
               psg_pkg::CA_MAX_CLASS_ID: q = {52'h0, psg_pkg::CA_MAX_INST_ID};
               psg_pkg::CA_MAX_INST_ID: q = {52'h0, psg_pkg::IA_PULSE_PARAMS};
               default: getOk = 1'b0;
            endcase
         end else begin
            unique case (attr)
               psg_pkg::IA_TIME_SYNC_ENABLE: q = {63'h0, s_r.enable};
               psg_pkg::IA_LOCKED: q = {63'h0, s_r.locked};
               psg_pkg::IA_TIME_US: q = {48'h0, 16'(s_r.timeNs / 64'd1000)};
               psg_pkg::IA_TIME_NS: q = s_r.timeNs;
               psg_pkg::IA_MASTER_OFFSET: q = s_r.offset;
               psg_pkg::IA_PEAK_OFFSET: q = s_r.peak;
               psg_pkg::IA_LINK_DELAY: q = s_r.delay;
               psg_pkg::IA_IRQ_STATUS: q = {61'h0, s_r.stat};
               psg_pkg::IA_IRQ_MASK: q = {61'h0, s_r.mask};
               psg_pkg::IA_PULSE_PARAMS: begin
                  unique case (memb)
                     psg_pkg::M_PRI_PERIOD: q = {32'h0, s_r.priPeriod};
                     psg_pkg::M_PRI_PHASE: q = {32'h0, s_r.priPhase};
                     psg_pkg::M_SEC_PERIOD: q = {32'h0, s_r.secPeriod};
                     psg_pkg::M_SEC_PHASE: q = {32'h0, s_r.secPhase};
                     psg_pkg::M_WIDTH_US: q = {32'h0, s_r.widthUs};
                     default: getOk = 1'b0;
                  endcase
               end
               default: getOk = 1'b0;
            endcase
         end
         s_nxt.rdata = getOk ? q : 64'h0;
         s_nxt.err = !getOk;
         if (getOk && inst && attr == psg_pkg::IA_IRQ_STATUS) begin
            s_nxt.stat = '0;
         end
      end
      if (wr) begin
         if (setOk) begin
            unique case (attr)
               psg_pkg::IA_TIME_SYNC_ENABLE: begin
                  s_nxt.enable = wdata[0];
                  valOk = 1'b1;
               end
               psg_pkg::IA_PEAK_OFFSET: begin
                  s_nxt.peak = mag(masterOffsetIn);
                  valOk = 1'b1;
               end
               psg_pkg::IA_IRQ_MASK: begin
                  s_nxt.mask = wdata[psg_pkg::IRQ_W-1:0];
                  valOk = 1'b1;
               end
               psg_pkg::IA_PULSE_PARAMS: begin
                  unique case (memb)
                     psg_pkg::M_PRI_PERIOD: begin
                        valOk = (w32 == 32'h0 || (w32 >= psg_pkg::PRI_PERIOD_MIN &&
                                 w32 <= psg_pkg::PRI_PERIOD_MAX)) &&
                                (w32 == 32'h0 || s_r.priPhase < w32) &&
                                width_fits(s_r.widthUs, w32, s_r.secPeriod);
                        if (valOk) s_nxt.priPeriod = w32;
                     end
                     psg_pkg::M_PRI_PHASE: begin
                        valOk = (w32 < s_r.priPeriod) || (w32 == 32'h0);
                        if (valOk) s_nxt.priPhase = w32;
                     end
                     psg_pkg::M_SEC_PERIOD: begin
                        valOk = (w32 == 32'h0 || (w32 >= psg_pkg::SEC_PERIOD_MIN &&
                                 w32 <= psg_pkg::SEC_PERIOD_MAX)) &&
                                (w32 == 32'h0 || s_r.secPhase < w32) &&
                                width_fits(s_r.widthUs, s_r.priPeriod, w32);
                        if (valOk) s_nxt.secPeriod = w32;
                     end
                     psg_pkg::M_SEC_PHASE: begin
                        valOk = (w32 < s_r.secPeriod) || (w32 == 32'h0);
                        if (valOk) s_nxt.secPhase = w32;
                     end
                     psg_pkg::M_WIDTH_US: begin
                        valOk = width_fits(w32, s_r.priPeriod, s_r.secPeriod);
                        if (valOk) s_nxt.widthUs = w32;
                     end
                     default: valOk = 1'b0;
                  endcase
                  s_nxt.reload = valOk;
               end
               default: valOk = 1'b0;
            endcase
         end
         s_nxt.err = !(setOk && valOk);
      end
      // Events are set after any read clear, so a coinciding event is kept
      if (pif.fire) s_nxt.stat[psg_pkg::IRQ_PULSE] = 1'b1;
      // The first sample after reset is not a lock change, whatever level it shows
      s_nxt.primed = 1'b1;
      if (s_r.primed && lockedIn != s_r.locked) s_nxt.stat[psg_pkg::IRQ_LOCK_CHG] = 1'b1;
      if (wr && !(setOk && valOk)) s_nxt.stat[psg_pkg::IRQ_REJECT] = 1'b1;
      s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         s_r <= '{enable: 1'b0, priPeriod: psg_pkg::PRI_PERIOD_RST,
                  priPhase: psg_pkg::PHASE_RST, secPeriod: psg_pkg::SEC_PERIOD_RST,
                  secPhase: psg_pkg::PHASE_RST, widthUs: psg_pkg::WIDTH_RST,
                  timeNs: 64'h0, locked: 1'b0, offset: 64'h0, peak: 64'h0, delay: 64'h0,
                  rdata: 64'h0, err: 1'b0, reload: 1'b0, stat: '0, mask: '0, irq: 1'b0,
                  primed: 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   a_irq_level: assert property (@(posedge clk_sys) disable iff (rst)
      irq == |(s_r.stat & s_r.mask))
      else $error("Interrupt does not follow masked status");
   a_class_set_err: assert property (@(posedge clk_sys) disable iff (rst)
      wr && !addr[psg_pkg::INST_BIT] |=> svcError && $stable(s_r.widthUs))
      else $error("Class level set was not refused");
   a_list_get_class: assert property (@(posedge clk_sys) disable iff (rst)
      rd && !addr[psg_pkg::INST_BIT] && svcCode == psg_pkg::SVC_GET_LIST |=> svcError)
      else $error("Class level list get was accepted");
   a_list_set_ok: assert property (@(posedge clk_sys) disable iff (rst)
      wr && addr == {1'b1, 3'h0, psg_pkg::IA_TIME_SYNC_ENABLE} &&
      svcCode == psg_pkg::SVC_SET_LIST |=> !svcError && timeSyncEnable == $past(wdata[0]))
      else $error("List set of enable failed");
   a_period_range: assert property (@(posedge clk_sys) disable iff (rst)
      s_r.priPeriod == 32'h0 ||
      (s_r.priPeriod >= psg_pkg::PRI_PERIOD_MIN && s_r.priPeriod <= psg_pkg::PRI_PERIOD_MAX))
      else $error("Primary period out of range");
   a_sec_range: assert property (@(posedge clk_sys) disable iff (rst)
      s_r.secPeriod == 32'h0 ||
      (s_r.secPeriod >= psg_pkg::SEC_PERIOD_MIN && s_r.secPeriod <= psg_pkg::SEC_PERIOD_MAX))
      else $error("Secondary period out of range");
   a_width_fit: assert property (@(posedge clk_sys) disable iff (rst)
      width_fits(s_r.widthUs, s_r.priPeriod, s_r.secPeriod))
      else $error("Pulse width breaks its limits");
   a_reject_keep: assert property (@(posedge clk_sys) disable iff (rst)
      svcError && $past(wr) |-> $stable(s_r.priPeriod) && $stable(s_r.priPhase))
      else $error("Rejected write changed a parameter");
   a_peak_hold: assert property (@(posedge clk_sys) disable iff (rst)
      !$past(wr) |-> s_r.peak >= $past(s_r.peak))
      else $error("Peak offset shrank without a write");
   a_read_time: assert property (@(posedge clk_sys) disable iff (rst)
      rd && svcCode == psg_pkg::SVC_GET_SINGLE &&
      addr == {1'b1, 3'h0, psg_pkg::IA_TIME_NS} |=> rdata == $past(s_r.timeNs))
      else $error("Time read returned wrong value");
   a_class_get_ok: assert property (@(posedge clk_sys) disable iff (rst)
      rd && svcCode == psg_pkg::SVC_GET_SINGLE && addr == {4'h0, psg_pkg::CA_REVISION} |=>
      !svcError && rdata == {48'h0, psg_pkg::CLASS_REVISION})
      else $error("Class revision read failed");
   a_read_lock: assert property (@(posedge clk_sys) disable iff (rst)
      rd && svcCode == psg_pkg::SVC_GET_SINGLE &&
      addr == {1'b1, 3'h0, psg_pkg::IA_LOCKED} |=> rdata == {63'h0, $past(s_r.locked)})
      else $error("Lock flag read returned wrong value");
   a_read_offset: assert property (@(posedge clk_sys) disable iff (rst)
      rd && svcCode == psg_pkg::SVC_GET_SINGLE &&
      addr == {1'b1, 3'h0, psg_pkg::IA_MASTER_OFFSET} |=> rdata == $past(s_r.offset))
      else $error("Master offset read returned wrong value");
   a_read_delay: assert property (@(posedge clk_sys) disable iff (rst)
      rd && svcCode == psg_pkg::SVC_GET_SINGLE &&
      addr == {1'b1, 3'h0, psg_pkg::IA_LINK_DELAY} |=> rdata == $past(s_r.delay))
      else $error("Link delay read returned wrong value");
   a_peak_reload: assert property (@(posedge clk_sys) disable iff (rst)
      wr && addr == {1'b1, 3'h0, psg_pkg::IA_PEAK_OFFSET} &&
      (svcCode == psg_pkg::SVC_SET_SINGLE || svcCode == psg_pkg::SVC_SET_LIST) |=>
      !svcError && s_r.peak == mag($past(masterOffsetIn)))
      else $error("Peak offset write did not restart tracking");
   a_phase_below: assert property (@(posedge clk_sys) disable iff (rst)
      s_r.priPeriod == 32'h0 || s_r.priPhase < s_r.priPeriod)
      else $error("Primary phase not below its period");
   a_sec_phase_below: assert property (@(posedge clk_sys) disable iff (rst)
      s_r.secPeriod == 32'h0 || s_r.secPhase < s_r.secPeriod)
      else $error("Secondary phase not below its period");
   c_reject: cover property (@(posedge clk_sys) disable iff (rst) svcError && $past(wr));
   c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
   c_pulse: cover property (@(posedge clk_sys) disable iff (rst) $rose(primaryPulse));
endmodule : psg_time_sync

// file: sim/psg_time_model.sv
`timescale 1ns/1ps
// Far-side time base: system time in ns, advancing by a step on every clock.
// A step of zero freezes time, so that attribute reads have a fixed expectation.
module psg_time_model #(
   parameter logic [63:0] START_NS = 64'h0000_0000_1234_5678
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [31:0] stepNs,
   output logic [63:0] sysTimeNs
);
   // Reload on reset as well, so a second reset starts from a known time
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sysTimeNs <= START_NS;
      end else begin
         sysTimeNs <= sysTimeNs + 64'(stepNs);
      end
   end
endmodule : psg_time_model

// file: sim/tb.sv
`timescale 1ns/1ps
`define CHK(NM, EXP, GOT) begin checks_done++; if ((GOT) !== (EXP)) begin mismatches++; \
   $display("BAD %s exp %0h got %0h", NM, EXP, GOT); end end
module tb;
   // k: bit1 write, bit0 refusal expected; v: write data or expected read data
   typedef struct {logic [1:0] k; logic [15:0] a; logic [7:0] s; logic [63:0] v;} psg_row_t;
   localparam logic [63:0] T0 = 64'h0000_0000_1234_5678;
   localparam logic [63:0] OFS = 64'hffff_ffff_ffff_ff85;
   localparam logic [63:0] DLY = 64'h0000_0000_0000_01c8;
   localparam logic [7:0] G = psg_pkg::SVC_GET_SINGLE;
   localparam logic [7:0] S = psg_pkg::SVC_SET_SINGLE;
   localparam logic [7:0] GL = psg_pkg::SVC_GET_LIST;
   localparam logic [7:0] SL = psg_pkg::SVC_SET_LIST;
   localparam logic [15:0] PP = 16'h8300;
   localparam logic [15:0] PH = 16'h9300;
   localparam logic [15:0] SP = 16'ha300;
   localparam logic [15:0] SH = 16'hb300;
   localparam logic [15:0] WU = 16'hc300;
   logic clk_sys, rst, wr, rd, lockedIn, svcError, timeSyncEnable, primaryPulse, irq;
   logic [15:0] addr;
   logic [7:0] svcCode;
   logic [63:0] wdata, rdata, sysTimeNs, masterOffsetIn, linkDelayIn, q;
   logic [31:0] stepNs;
   logic e;
   int mismatches, checks_done, cycles, t, hi;
   psg_row_t rows[] = '{
      '{2'h0, 16'h0001, G, 64'h1}, '{2'h0, 16'h0002, G, 64'h1},
      '{2'h0, 16'h0003, G, 64'h1}, '{2'h0, 16'h0006, G, 64'h7},
      '{2'h0, 16'h0007, G, 64'h300}, '{2'h3, 16'h0001, S, 64'h1},
      '{2'h1, 16'h0001, GL, 64'h0},
      '{2'h3, 16'h0001, SL, 64'h1},
      '{2'h0, WU, G, 64'h4}, '{2'h0, PP, GL, 64'h0}, '{2'h0, SP, G, 64'h0},
      '{2'h0, PH, G, 64'h0}, '{2'h0, SH, G, 64'h0},
      '{2'h0, 16'h8002, G, 64'h1}, '{2'h0, 16'h8004, G, T0},
      '{2'h0, 16'h8003, G, (T0 / 64'h3e8) & 64'hffff},
      '{2'h0, 16'h8005, G, OFS}, '{2'h0, 16'h8007, G, DLY},
      '{2'h0, 16'h8006, G, 64'h7b}, '{2'h1, 16'h8008, G, 64'h0},
      '{2'h3, 16'h8002, S, 64'h0}, '{2'h3, 16'h8004, S, 64'h0},
      '{2'h3, 16'h8005, S, 64'h0}, '{2'h3, 16'h8007, S, 64'h0},
      '{2'h2, 16'h8001, S, 64'h1}, '{2'h0, 16'h8001, G, 64'h1},
      '{2'h2, 16'h8001, SL, 64'h1}, '{2'h0, 16'h8001, G, 64'h1},
      '{2'h3, SP, S, 64'h270f}, '{2'h3, SP, S, 64'h3b9aca00},
      '{2'h2, SP, S, 64'h3b9ac9ff}, '{2'h2, SP, S, 64'h2710},
      '{2'h0, SP, GL, 64'h2710},
      '{2'h3, SH, S, 64'h2710}, '{2'h2, SH, SL, 64'h270f},
      '{2'h0, SH, G, 64'h270f},
      '{2'h3, PP, S, 64'h1869f}, '{2'h3, PP, S, 64'h3d0901},
      '{2'h2, PP, S, 64'h3d0900}, '{2'h0, PP, G, 64'h3d0900},
      '{2'h3, WU, S, 64'h0}, '{2'h3, WU, S, 64'h1f5}, '{2'h3, WU, S, 64'ha},
      '{2'h2, WU, S, 64'h9}, '{2'h0, WU, G, 64'h9}, '{2'h2, WU, SL, 64'h4},
      '{2'h3, PH, S, 64'h3d0900}, '{2'h2, PH, S, 64'h3d08ff},
      '{2'h3, PP, S, 64'h186a0}, '{2'h0, PP, G, 64'h3d0900},
      '{2'h2, PH, S, 64'h0}};

   psg_time_model #(.START_NS(T0)) model_u (.clk_sys(clk_sys), .rst(rst), .stepNs(stepNs),
      .sysTimeNs(sysTimeNs));
   psg_time_sync dut_u (.clk_sys(clk_sys), .rst(rst), .addr(addr), .svcCode(svcCode),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .svcError(svcError),
      .sysTimeNs(sysTimeNs), .lockedIn(lockedIn), .masterOffsetIn(masterOffsetIn),
      .linkDelayIn(linkDelayIn), .timeSyncEnable(timeSyncEnable),
      .primaryPulse(primaryPulse), .irq(irq));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic give_verdict;
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   // Hang guard: the whole sequence needs well under half of this
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         give_verdict();
      end
   end

   // One strobe cycle; the answer is taken in the cycle after it only
   task automatic xfer(input psg_row_t r);
      @(posedge clk_sys);
      addr <= r.a;
      svcCode <= r.s;
      wdata <= r.v;
      wr <= r.k[1];
      rd <= !r.k[1];
      @(posedge clk_sys);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      q = rdata;
      e = svcError;
   endtask : xfer

   task automatic run(input psg_row_t r);
      xfer(r);
      `CHK("rdata", (r.k == 2'h0) ? r.v : 64'h0, q)
      `CHK("svcError", r.k[0], e)
   endtask : run

   task automatic rise(output int n);
      logic p;
      n = 0;
      p = primaryPulse;
      while (!(p === 1'b0 && primaryPulse === 1'b1) && n < 5000) begin
         p = primaryPulse;
         @(posedge clk_sys);
         #1;
         n++;
      end
   endtask : rise

   task automatic high_cnt(output int h);
      h = 0;
      while (primaryPulse === 1'b1 && h < 1000) begin
         @(posedge clk_sys);
         #1;
         h++;
      end
   endtask : high_cnt

   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 16'h0000;
      svcCode = 8'h00;
      wdata = 64'h0;
      lockedIn = 1'b1;
      masterOffsetIn = OFS;
      linkDelayIn = DLY;
      stepNs = 32'h0;
      repeat (4) @(posedge clk_sys);
      rst <= 1'b0;
      foreach (rows[i]) run(rows[i]);
      `CHK("enable", 1'b1, timeSyncEnable)
      // Peak follows the magnitude and restarts from the present offset on a write
      @(posedge clk_sys);
      masterOffsetIn <= 64'hffff_ffff_ffff_fe0c;
      repeat (4) @(posedge clk_sys);
      masterOffsetIn <= 64'hc8;
      run('{2'h0, 16'h8006, G, 64'h1f4});
      run('{2'h2, 16'h8006, S, 64'h0});
      repeat (2) @(posedge clk_sys);
      run('{2'h0, 16'h8006, G, 64'hc8});
      // Pulse train: 50 ns per cycle, so 100 us is 2000 cycles and 4 us is 80
      stepNs <= 32'h32;
      run('{2'h2, PP, S, 64'h186a0});
      rise(t);
      `CHK("phase0", 1'b1, (sysTimeNs % 64'h186a0) <= 64'hfa)
      high_cnt(hi);
      `CHK("width", 1'b1, hi >= 79 && hi <= 81)
      rise(t);
      `CHK("period", 2000, hi + t)
      run('{2'h2, PH, S, 64'h7530});
      rise(t);
      `CHK("phase", 1'b1, ((sysTimeNs - 64'h7530) % 64'h186a0) <= 64'hfa)
      run('{2'h2, PH, S, 64'h0});
      run('{2'h2, PP, S, 64'h0});
      // Secondary period is still set; nothing may come out of it
      repeat (3) @(posedge clk_sys);
      hi = 0;
      repeat (3000) begin
         @(posedge clk_sys);
         #1;
         hi += int'(primaryPulse === 1'b1);
      end
      `CHK("idle", 0, hi)
      // Interrupt: refused write raises bit 2, unmasked only
      run('{2'h0, 16'h83f0, G, 64'h5});
      run('{2'h0, 16'h83f0, G, 64'h0});
      run('{2'h2, 16'h83f1, S, 64'h4});
      run('{2'h3, WU, S, 64'h1f5});
      repeat (2) @(posedge clk_sys);
      #1;
      `CHK("irq", 1'b1, irq)
      run('{2'h0, 16'h83f0, G, 64'h4});
      @(posedge clk_sys);
      lockedIn <= 1'b0;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("irq", 1'b0, irq)
      run('{2'h0, 16'h8002, G, 64'h0});
      run('{2'h0, 16'h83f0, G, 64'h2});
      // Second reset in mid-run brings back the defaults
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (4) @(posedge clk_sys);
      #1;
      `CHK("pulse", 1'b0, primaryPulse)
      `CHK("enable", 1'b0, timeSyncEnable)
      @(posedge clk_sys);
      rst <= 1'b0;
      run('{2'h0, WU, G, 64'h4});
      run('{2'h0, SP, G, 64'h0});
      run('{2'h0, PH, G, 64'h0});
      give_verdict();
   end
endmodule : tb
